// >>> shared/lsp_pkg.sv
// package: constants, carriers and helpers of the cache sram pin interface
package lsp_pkg;
  //--------------------------------------------------------------------------
  // Overview of operation
  // - on writes drive one parity bit per data byte, all eight lanes
  // - parity bit 0 covers data bits 0..7; higher bits follow in order
  // - each lane plus its parity bit holds an odd count of ones
  // - read parity returns with the read data, odd per byte
  // - data and parity lines float one cycle on read/write turnaround
  // - select low only in selected cycles, high during hard reset
  // - write strobe low only in write cycles, high during hard reset
  // - two identical memory clocks by default, each feeding four memories
  // - differential mode drives clock b as the inverse of clock a
  // - memory clocks and align clock stay low during hard reset
  // - align clock loops back; its returned edge aligns cache clocking
  // - if enabled, sleep pin follows nap/sleep on cache clock; low in reset
  // - after sleep pin falls, two memory clocks pass before any access
  //--------------------------------------------------------------------------

  localparam int DATA_W    = 64;             // data bus width
  localparam int LANE_W    = 8;              // bits per byte lane
  localparam int LANES     = DATA_W / LANE_W;
  localparam int ADDR_W    = 18;             // address bus width
  localparam int WAKE_MCLK = 2;              // memory clocks idle after sleep exit
  localparam int WAKE_W    = 2;
  localparam logic [WAKE_W-1:0] WAKE_CNT = WAKE_W'(WAKE_MCLK);

  // one access request from the cache controller
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [0:DATA_W-1] data;
  } lsp_req_t;

  // answer to a read access
  typedef struct packed {
    logic              par_err;
    logic [0:DATA_W-1] data;
  } lsp_rsp_t;

  // pin sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_TURN = 5'h02,
    ST_ACC  = 5'h04,
    ST_RDW  = 5'h08,
    ST_DONE = 5'h10
  } lsp_state_t;

  // odd parity per byte lane, lane 0 = bits 0..7 in bus numbering
  function automatic logic [0:LANES-1] lsp_odd_par(input logic [0:DATA_W-1] d);
    logic [0:LANES-1] p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i] = ~^d[i*LANE_W +: LANE_W];
    end
    return p;
  endfunction
endpackage

// >>> src/lsp_sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ns
module lsp_sync2 #(
  parameter int W = 1 // number of independent levels
) (
  input  wire logic         clk_i,   // destination clock
  input  wire logic         reset_i, // async reset, active high
  input  wire logic [W-1:0] d_i,     // levels from another domain
  output logic      [W-1:0] q_o      // synchronised levels
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// >>> src/lsp_buf2.sv
// small request buffer with valid/ready on both sides
`timescale 1ns/1ns
module lsp_buf2 #(
  parameter int W     = 8, // word width
  parameter int DEPTH = 2  // number of entries
) (
  input  wire logic         clk_i,       // clock
  input  wire logic         reset_i,     // async reset, active high
  input  wire logic         in_valid_i,  // word offered
  output logic              in_ready_o,  // room for a word
  input  wire logic [W-1:0] in_data_i,   // offered word
  output logic              out_valid_o, // head word present
  input  wire logic         out_ready_i, // drain takes head
  output logic      [W-1:0] out_data_o   // head word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          push;
  logic          pop;

  // pointer advance with wrap
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem[rp];

  // occupancy after this cycle
  always_comb begin
    next_cnt = cnt;
    if (push & ~pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop & ~push) begin
      next_cnt = cnt - 1'b1;
    end
  end

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end

  // pointers and registered full/empty flags
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp          <= '0;
      rp          <= '0;
      cnt         <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wp <= bump(wp);
      end
      if (pop) begin
        rp <= bump(rp);
      end
      cnt         <= next_cnt;
      in_ready_o  <= next_cnt != FULL;
      out_valid_o <= next_cnt != '0;
    end
  end
endmodule

// >>> src/lsp_pin_if.sv
// cache sram pin interface: request handshake, pin sequencer, clocks, sleep
`timescale 1ns/1ns
module lsp_pin_if (
  input  wire logic                               clock_i,              // core clock
  input  wire logic                               reset_i,              // hard reset, high
  input  wire logic                               link_clk_i,           // cache clock
  input  wire logic                               req_valid_i,          // request offered
  output logic                                    req_ready_o,          // request taken
  input  wire lsp_pkg::lsp_req_t                  req_i,                // request word
  output logic                                    rsp_valid_o,          // read answer pulse
  output lsp_pkg::lsp_rsp_t                       rsp_o,                // read answer
  input  wire logic                               diff_clk_en_i,        // clock b inverted
  input  wire logic                               sleep_en_i,           // sleep pin enable
  input  wire logic                               power_save_i,         // nap or sleep state
  output logic [lsp_pkg::ADDR_W-1:0]              cache_addr_o,         // memory address
  input  wire logic [0:lsp_pkg::DATA_W-1]         cache_data_bus_i,     // data pins in
  output logic [0:lsp_pkg::DATA_W-1]              cache_data_bus_o,     // data pins out
  output logic                                    cache_data_bus_oe_o,  // data drive
  input  wire logic [0:lsp_pkg::LANES-1]          cache_parity_lines_i, // parity in
  output logic [0:lsp_pkg::LANES-1]               cache_parity_lines_o, // parity out
  output logic                                    cache_parity_lines_oe_o, // parity drive
  output logic                                    cache_mem_select_n_o, // select, low
  output logic                                    cache_mem_write_n_o,  // write, low
  output logic                                    cache_mem_clock_a_o,  // memory clock a
  output logic                                    cache_mem_clock_b_o,  // memory clock b
  output logic                                    clock_align_out_o,    // align loop out
  input  wire logic                               clock_align_in_i,     // align loop in
  output logic                                    memory_sleep_out_o    // memory sleep
);
  localparam int DW = lsp_pkg::DATA_W;
  localparam int NL = lsp_pkg::LANES;
  localparam int LW = lsp_pkg::LANE_W;

  //--------------------------------------------------------------------------
  // core domain
  //--------------------------------------------------------------------------
  lsp_pkg::lsp_req_t head;
  logic              head_vld;
  logic              pop;
  logic              req_tog;
  logic              ack_seen;
  logic              ack_s;
  logic              ack_tog;
  lsp_pkg::lsp_rsp_t rsp_q;

  // two entries absorb requests while the link is busy
  lsp_buf2 #(
    .W     ($bits(lsp_pkg::lsp_req_t)),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clock_i),
    .reset_i     (reset_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (req_i),
    .out_valid_o (head_vld),
    .out_ready_i (pop),
    .out_data_o  (head)
  );

  // access-complete toggle from the link side
  lsp_sync2 #(
    .W (1)
  ) u_ack_sync (
    .clk_i   (clock_i),
    .reset_i (reset_i),
    .d_i     (ack_tog),
    .q_o     (ack_s)
  );

  assign pop = ack_s != ack_seen;

  // hand the head word to the link, retire it on completion
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      req_tog     <= 1'b0;
      ack_seen    <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (head_vld && req_tog == ack_seen) begin
        req_tog <= ~req_tog; // head stays put until its completion
      end
      if (pop) begin
        ack_seen    <= ack_s;
        rsp_valid_o <= ~head.wr;
        rsp_o       <= rsp_q; // stable: written before the toggle
      end
    end
  end

  //--------------------------------------------------------------------------
  // link domain: level crossings
  //--------------------------------------------------------------------------
  logic [5:0]        ls;
  logic              req_s;
  logic              diff_s;
  logic              sleep_en_s;
  logic              ps_s;
  logic              align_s;
  logic              link_run;
  logic [0:DW+NL-1]  rd_s;
  logic [0:DW-1]     rd_data;
  logic [0:NL-1]     rd_par;
  logic              rd_err;

  lsp_sync2 #(
    .W (6)
  ) u_lvl_sync (
    .clk_i   (link_clk_i),
    .reset_i (reset_i),
    .d_i     ({req_tog, diff_clk_en_i, sleep_en_i, power_save_i, clock_align_in_i, 1'b1}),
    .q_o     (ls)
  );

  assign {req_s, diff_s, sleep_en_s, ps_s, align_s, link_run} = ls;

  // read pins pass two flops before use
  lsp_sync2 #(
    .W (DW + NL)
  ) u_rd_sync (
    .clk_i   (link_clk_i),
    .reset_i (reset_i),
    .d_i     ({cache_data_bus_i, cache_parity_lines_i}),
    .q_o     (rd_s)
  );

  assign rd_data = rd_s[0:DW-1];
  assign rd_par  = rd_s[DW +: NL];
  assign rd_err  = |(lsp_pkg::lsp_odd_par(rd_data) ^ rd_par);

  //--------------------------------------------------------------------------
  // link domain: memory clocks and align loop
  //--------------------------------------------------------------------------
  logic step;
  logic align_q;
  logic aligned;

  // memory clock is half the cache clock; pins move on its falling edge
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cache_mem_clock_a_o <= 1'b0;
      cache_mem_clock_b_o <= 1'b0;
      clock_align_out_o   <= 1'b0;
    end else if (link_run) begin
      cache_mem_clock_a_o <= ~cache_mem_clock_a_o;
      cache_mem_clock_b_o <= diff_s ? cache_mem_clock_a_o : ~cache_mem_clock_a_o;
      clock_align_out_o   <= ~cache_mem_clock_a_o;
    end
  end

  assign step = cache_mem_clock_a_o;

  // no access until the looped-back clock shows a rising edge
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      align_q <= 1'b0;
      aligned <= 1'b0;
    end else begin
      align_q <= align_s;
      if (align_s && !align_q) begin
        aligned <= 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------------
  // link domain: low-power pin
  //--------------------------------------------------------------------------
  logic                      sleep_req;
  logic [lsp_pkg::WAKE_W-1:0] wake;
  lsp_pkg::lsp_state_t       st;
  lsp_pkg::lsp_state_t       next_st;

  assign sleep_req = sleep_en_s & ps_s;

  // enter only when idle; on exit hold off accesses for the wake time
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      memory_sleep_out_o <= 1'b0;
      wake               <= '0;
    end else if (step) begin
      if (!memory_sleep_out_o && sleep_req && st == lsp_pkg::ST_IDLE) begin
        memory_sleep_out_o <= 1'b1;
      end else if (memory_sleep_out_o && !sleep_req) begin
        memory_sleep_out_o <= 1'b0;
        wake               <= lsp_pkg::WAKE_CNT;
      end else if (wake != '0) begin
        wake <= wake - 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------------
  // link domain: access sequencer
  //--------------------------------------------------------------------------
  lsp_pkg::lsp_req_t acc;
  lsp_pkg::lsp_req_t acc_next;
  logic              req_seen;
  logic              last_wr;
  logic              ok;
  logic              start;

  assign ok       = aligned & ~memory_sleep_out_o & (wake == '0) & ~sleep_req;
  assign start    = step & (st == lsp_pkg::ST_IDLE) & (req_s != req_seen) & ok;
  assign acc_next = start ? head : acc;

  // direction change inserts a released turnaround cycle
  always_comb begin
    next_st = st;
    case (st)
      lsp_pkg::ST_IDLE: begin
        if (start) begin
          next_st = (head.wr != last_wr) ? lsp_pkg::ST_TURN : lsp_pkg::ST_ACC;
        end
      end
      lsp_pkg::ST_TURN: begin
        if (step) begin
          next_st = lsp_pkg::ST_ACC;
        end
      end
      lsp_pkg::ST_ACC: begin
        if (step) begin
          next_st = acc.wr ? lsp_pkg::ST_DONE : lsp_pkg::ST_RDW;
        end
      end
      lsp_pkg::ST_RDW: begin
        if (step) begin
          next_st = lsp_pkg::ST_DONE;
        end
      end
      lsp_pkg::ST_DONE: begin
        next_st = lsp_pkg::ST_IDLE;
      end
      default: begin
        next_st = lsp_pkg::ST_IDLE;
      end
    endcase
  end

  // state and request bookkeeping
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st       <= lsp_pkg::ST_IDLE;
      acc      <= '0;
      req_seen <= 1'b0;
      ack_tog  <= 1'b0;
      last_wr  <= 1'b0;
    end else begin
      st <= next_st;
      if (start) begin
        acc      <= head; // stable while its toggle is pending
        req_seen <= req_s;
      end
      if (st == lsp_pkg::ST_DONE) begin
        ack_tog <= ~ack_tog;
        last_wr <= acc.wr;
      end
    end
  end

  // read answer captured at the end of the read-wait cycle
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_q <= '0;
    end else if (st == lsp_pkg::ST_RDW && step) begin
      rsp_q <= '{par_err: rd_err, data: rd_data};
    end
  end

  // pin drivers follow the next state
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cache_mem_select_n_o    <= 1'b1;
      cache_mem_write_n_o     <= 1'b1;
      cache_data_bus_oe_o     <= 1'b0;
      cache_parity_lines_oe_o <= 1'b0;
      cache_addr_o            <= '0;
      cache_data_bus_o        <= '0;
      cache_parity_lines_o    <= '0;
    end else begin
      cache_mem_select_n_o    <= next_st != lsp_pkg::ST_ACC;
      cache_mem_write_n_o     <= !(next_st == lsp_pkg::ST_ACC && acc_next.wr);
      cache_data_bus_oe_o     <= next_st == lsp_pkg::ST_ACC && acc_next.wr;
      cache_parity_lines_oe_o <= next_st == lsp_pkg::ST_ACC && acc_next.wr;
      if (start) begin
        cache_addr_o         <= head.addr; // static between accesses
        cache_data_bus_o     <= head.data;
        cache_parity_lines_o <= lsp_pkg::lsp_odd_par(head.data);
      end
    end
  end

  //--------------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------------
  property p_par_odd;
    @(posedge link_clk_i) disable iff (reset_i)
      cache_parity_lines_oe_o |-> cache_parity_lines_o == lsp_pkg::lsp_odd_par(cache_data_bus_o);
  endproperty
  a_par_odd: assert property (p_par_odd) else $error("parity not odd");

  property p_lane0;
    @(posedge link_clk_i) disable iff (reset_i)
      cache_data_bus_oe_o |-> ^{cache_data_bus_o[0:LW-1], cache_parity_lines_o[0]};
  endproperty
  a_lane0: assert property (p_lane0) else $error("parity bit 0 not on lane 0");

  property p_turn;
    @(posedge link_clk_i) disable iff (reset_i)
      $rose(cache_data_bus_oe_o) && !last_wr |-> $past(st) == lsp_pkg::ST_TURN;
  endproperty
  a_turn: assert property (p_turn) else $error("no turnaround before write");

  property p_sel;
    @(posedge link_clk_i) disable iff (reset_i)
      $fell(cache_mem_select_n_o) |-> ##1 !cache_mem_select_n_o ##1 cache_mem_select_n_o;
  endproperty
  a_sel: assert property (p_sel) else $error("select not one memory cycle");

  property p_we;
    @(posedge link_clk_i) disable iff (reset_i)
      !cache_mem_write_n_o |-> !cache_mem_select_n_o && cache_data_bus_oe_o && acc.wr;
  endproperty
  a_we: assert property (p_we) else $error("write strobe without write");

  property p_clk_b;
    @(posedge link_clk_i) disable iff (reset_i)
      cache_mem_clock_b_o == (cache_mem_clock_a_o ^ $past(diff_s));
  endproperty
  a_clk_b: assert property (p_clk_b) else $error("clock b phase wrong");

  property p_align;
    @(posedge link_clk_i) disable iff (reset_i)
      !cache_mem_select_n_o |-> aligned;
  endproperty
  a_align: assert property (p_align) else $error("access before alignment");

  property p_sleep_en;
    @(posedge link_clk_i) disable iff (reset_i)
      $rose(memory_sleep_out_o) |-> $past(sleep_en_s) && $past(ps_s);
  endproperty
  a_sleep_en: assert property (p_sleep_en) else $error("sleep pin while disabled");

  property p_wake;
    @(posedge link_clk_i) disable iff (reset_i)
      $fell(memory_sleep_out_o) |-> cache_mem_select_n_o [*4];
  endproperty
  a_wake: assert property (p_wake) else $error("access too soon after sleep");

  c_write: cover property (@(posedge link_clk_i) disable iff (reset_i) !cache_mem_write_n_o);
  c_read: cover property (@(posedge link_clk_i) disable iff (reset_i) st == lsp_pkg::ST_RDW);
  c_turn: cover property (@(posedge link_clk_i) disable iff (reset_i) st == lsp_pkg::ST_TURN);
  c_sleep: cover property (@(posedge link_clk_i) disable iff (reset_i) $rose(memory_sleep_out_o));
endmodule

// >>> tb/lsp_sram_model.sv
// behavioural cache sram seen across the pin interface
`timescale 1ns/1ns
module lsp_sram_model (
  input  wire logic        mclk_i,    // memory clock a
  input  wire logic        sel_n_i,   // select, low
  input  wire logic        wr_n_i,    // write strobe, low
  input  wire logic [17:0] addr_i,    // address
  input  wire logic [0:63] data_i,    // data lines seen
  input  wire logic [0:7]  par_i,     // parity lines seen
  input  wire logic [0:7]  bad_par_i, // lanes answered with wrong parity
  output logic      [0:63] data_o,    // data lines driven
  output logic      [0:7]  par_o,     // parity lines driven
  output logic             oe_o,      // memory drives the lines
  output int               writes_o,  // writes taken
  output int               par_err_o  // writes with wrong parity
);
  logic [0:63] mem [logic [17:0]];
  logic [0:63] rd;
  int          hold;

  // odd parity per lane, lane 0 = bits 0..7
  function automatic logic [0:7] odd8(input logic [0:63] d);
    for (int i = 0; i < 8; i++) begin
      odd8[i] = ~^d[i*8 +: 8];
    end
  endfunction

  initial begin
    data_o = '0;
    par_o = '0;
    oe_o = 1'b0;
    writes_o = 0;
    par_err_o = 0;
    hold = 0;
  end

  // sample on rising memory clock; read data stands two memory cycles
  always @(posedge mclk_i) begin
    if (!sel_n_i && !wr_n_i) begin
      mem[addr_i] = data_i;
      writes_o++;
      if (par_i !== odd8(data_i)) par_err_o++;
    end else if (!sel_n_i) begin
      rd = mem.exists(addr_i) ? mem[addr_i] : '0;
      data_o <= rd;
      par_o <= odd8(rd) ^ bad_par_i;
      oe_o <= 1'b1;
      hold = 2;
    end else if (hold > 0) begin
      hold--;
      if (hold == 0) begin
        // released lines show the inverse, not a stale copy
        oe_o <= 1'b0;
        data_o <= ~data_o;
        par_o <= ~par_o;
      end
    end
  end
endmodule

// >>> tb/lsp_pin_if_test.sv
// self-checking bench of the cache sram pin interface
`timescale 1ns/1ns
module lsp_pin_if_test;
  logic clock_i, reset_i, link_clk_i, req_valid_i, req_ready_o, rsp_valid_o;
  logic diff_clk_en_i, sleep_en_i, power_save_i, dq_oe, dp_oe, moe;
  logic sel_n, wr_n, ck_a, ck_b, al_o, al_i, zz;
  lsp_pkg::lsp_req_t req_i;
  lsp_pkg::lsp_rsp_t rsp_o;
  logic [17:0]       addr;
  logic [0:63]       dq_o, dq_i, md;
  logic [0:7]        dp_o, dp_i, mp, bad_par;
  int writes, par_errs, n_mismatch, num_checks, clash, gap_err, stalls;
  time t_wake;
  logic [63:0] pat [4] = '{64'h0, 64'hffffffffffffffff,
                           64'h0123456789abcdef, 64'h8000000000000001};

  // shared lines resolve to whoever drives; align clock loops back
  assign dq_i = dq_oe ? dq_o : md;
  assign dp_i = dp_oe ? dp_o : mp;
  assign #1 al_i = al_o;

  lsp_pin_if u_lsp_pin_if (.clock_i(clock_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .diff_clk_en_i(diff_clk_en_i),
    .sleep_en_i(sleep_en_i), .power_save_i(power_save_i), .cache_addr_o(addr),
    .cache_data_bus_i(dq_i), .cache_data_bus_o(dq_o), .cache_data_bus_oe_o(dq_oe),
    .cache_parity_lines_i(dp_i), .cache_parity_lines_o(dp_o),
    .cache_parity_lines_oe_o(dp_oe), .cache_mem_select_n_o(sel_n),
    .cache_mem_write_n_o(wr_n), .cache_mem_clock_a_o(ck_a), .cache_mem_clock_b_o(ck_b),
    .clock_align_out_o(al_o), .clock_align_in_i(al_i), .memory_sleep_out_o(zz));

  lsp_sram_model u_lsp_sram_model (.mclk_i(ck_a), .sel_n_i(sel_n), .wr_n_i(wr_n),
    .addr_i(addr), .data_i(dq_i), .par_i(dp_i), .bad_par_i(bad_par), .data_o(md),
    .par_o(mp), .oe_o(moe), .writes_o(writes), .par_err_o(par_errs));

  //--------------------------------------------------------------------------
  // clocks and monitors
  //--------------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #32 link_clk_i = ~link_clk_i;
  end
  // both sides driving the shared lines at once
  always @(posedge clock_i) if ((dq_oe || dp_oe) && moe) clash++;
  always @(negedge zz) t_wake = $time;
  // no select while asleep, nor within two memory clocks (256 ns) of wake
  always @(negedge sel_n) begin
    if (zz || (t_wake != 0 && $time - t_wake < 256)) gap_err++;
  end

  //--------------------------------------------------------------------------
  // shared tasks
  //--------------------------------------------------------------------------
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({63'h0, got}, {63'h0, exp});
  endtask
  task automatic send(input logic wr, input logic [17:0] a, input logic [63:0] d);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_i <= '{wr: wr, addr: a, data: d};
    do begin
      @(posedge clock_i);
      n++;
      if (req_ready_o !== 1'b1) stalls++;
    end while (req_ready_o !== 1'b1 && n < 2000);
    if (n >= 2000) chk_bit(1'b0, 1'b1);
    if (n >= 2000) stop_test();
  endtask
  task automatic read(input logic [17:0] a, input logic [63:0] d, input logic e);
    int n;
    n = 0;
    send(1'b0, a, 64'h0);
    req_valid_i <= 1'b0;
    do begin
      @(posedge clock_i);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 4000);
    chk_bit(rsp_valid_o, 1'b1);
    if (n >= 4000) stop_test();
    chk_word(rsp_o.data, d);
    chk_bit(rsp_o.par_err, e);
  endtask
  task automatic wait_writes(input int w);
    int n;
    for (n = 0; n < 4000 && writes != w; n++) @(posedge clock_i);
    chk_word(64'(writes), 64'(w));
    if (n >= 4000) stop_test();
  endtask

  //--------------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------------
  task automatic t_reset();
    chk_bit(sel_n, 1'b1);
    chk_bit(wr_n, 1'b1);
    chk_word({ck_a, ck_b, al_o}, 64'h0);
    chk_bit(zz, 1'b0);
  endtask
  task automatic t_rw();
    for (int i = 0; i < 4; i++) send(1'b1, 18'(i), pat[i]);
    req_valid_i <= 1'b0;
    wait_writes(4);
    chk_bit(stalls > 0, 1'b1);
    chk_word(64'(par_errs), 64'h0);
    for (int i = 0; i < 4; i++) read(18'(i), pat[i], 1'b0);
  endtask
  task automatic t_bad_par();
    for (int i = 0; i < 8; i++) begin
      bad_par <= 8'h80 >> i;
      read(18'h2, pat[2], 1'b1);
    end
    bad_par <= 8'h00;
    read(18'h3, pat[3], 1'b0);
  endtask
  task automatic t_clk(input logic diff);
    diff_clk_en_i <= diff;
    repeat (200) @(posedge clock_i);
    for (int i = 0; i < 32; i++) begin
      repeat (3) @(posedge clock_i);
      chk_bit(ck_b, ck_a ^ diff);
    end
  endtask
  task automatic t_sleep();
    int n;
    power_save_i <= 1'b1;
    repeat (200) @(posedge clock_i);
    chk_bit(zz, 1'b0);
    sleep_en_i <= 1'b1;
    for (n = 0; n < 400 && zz !== 1'b1; n++) @(posedge clock_i);
    chk_bit(zz, 1'b1);
    if (n >= 400) stop_test();
    send(1'b1, 18'h3ffff, pat[2]);
    req_valid_i <= 1'b0;
    repeat (300) @(posedge clock_i);
    chk_word(64'(writes), 64'h4);
    power_save_i <= 1'b0;
    wait_writes(5);
    chk_bit(zz, 1'b0);
    chk_word(64'(gap_err), 64'h0);
    read(18'h3ffff, pat[2], 1'b0);
  endtask

  //--------------------------------------------------------------------------
  // main sequence
  //--------------------------------------------------------------------------
  initial begin
    {reset_i, req_valid_i, diff_clk_en_i, sleep_en_i, power_save_i} = 5'h10;
    req_i = '0;
    bad_par = '0;
    {n_mismatch, num_checks, clash, gap_err, stalls, t_wake} = '0;
    repeat (8) @(posedge link_clk_i);
    t_reset();
    @(posedge clock_i);
    reset_i <= 1'b0;
    t_rw();
    t_bad_par();
    t_clk(1'b0);
    t_clk(1'b1);
    t_clk(1'b0);
    t_sleep();
    chk_word(64'(clash), 64'h0);
    stop_test();
  end
endmodule
